// ### hdl/aux_test_pkg.sv
package aux_test_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_AUX_SEL    = 6'h38;
    localparam logic [5:0] IDX_DAC_ONE    = 6'h39;
    localparam logic [5:0] IDX_DAC_TWO    = 6'h3a;
    localparam logic [5:0] IDX_ADC_IQ     = 6'h3b;
    localparam logic [5:0] IDX_PROD_A     = 6'h3c;
    localparam logic [5:0] IDX_PROD_B     = 6'h3d;
    localparam logic [5:0] IDX_PROD_C     = 6'h3e;
    localparam logic [5:0] IDX_PROD_D     = 6'h3f;
    localparam logic [5:0] IDX_TEST_SEL   = 6'h31;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_AUX_SEL    = 8'h00;
    localparam logic [7:0] RST_DAC        = 8'h00;
    localparam logic [7:0] RST_PROD_A     = 8'hff;
    localparam logic [7:0] RST_PROD_B     = 8'h00;
    localparam logic [7:0] RST_PROD_C     = 8'h03;
    localparam logic [7:0] RST_PROD_D     = 8'h00;
    localparam logic [2:0] RST_TEST_SEL   = 3'h0;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int FIRST_SEL_LSB  = 4;
    localparam int SECOND_SEL_LSB = 0;
    localparam int DAC_VALUE_MSB  = 5;
    localparam int ADC_I_LSB      = 4;
    localparam int ADC_Q_LSB      = 0;

    // ------------------------------------------------------------------
    // selector codes
    // ------------------------------------------------------------------
    localparam logic [3:0] SEL_TRISTATE   = 4'h0;
    localparam logic [3:0] SEL_TEST_DAC   = 4'h1;
    localparam logic [3:0] SEL_CORR_ONE   = 4'h2;
    localparam logic [3:0] SEL_MIN_LEVEL  = 4'h4;
    localparam logic [3:0] SEL_ADC_I      = 4'h5;
    localparam logic [3:0] SEL_ADC_Q      = 4'h6;
    localparam logic [3:0] SEL_HIGH       = 4'ha;
    localparam logic [3:0] SEL_LOW        = 4'hb;
    localparam logic [3:0] SEL_TX_WINDOW  = 4'hc;
    localparam logic [3:0] SEL_RX_WINDOW  = 4'hd;
    localparam logic [3:0] SEL_SUBCARRIER = 4'he;
    localparam logic [3:0] SEL_TEST_BUS   = 4'hf;

    // frame phase reported by the transceiver
    typedef enum logic [2:0] {
        PH_IDLE   = 3'h0,
        PH_START  = 3'h1,
        PH_DATA   = 3'h2,
        PH_PARITY = 3'h3,
        PH_CRC    = 3'h4
    } frame_phase_e;

    // frame status from the transceiver
    typedef struct packed {
        frame_phase_e txPhase;     // transmit frame phase
        frame_phase_e rxPhase;     // receive frame phase
        logic         baseRate;    // 1: 106 kBd, 0: a higher rate
        logic         subcarrier;  // subcarrier detected
    } frame_status_s;

    // analog-side samples
    typedef struct packed {
        logic [3:0] adcI;          // I-channel sample
        logic [3:0] adcQ;          // Q-channel sample
        logic [5:0] minimum_signal_level;      // minimum signal level
        logic       corrOne;       // correlator signal one
    } analog_in_s;

    // drive for one auxiliary pin
    typedef struct packed {
        logic       digital;       // digital level when analogEn low
        logic       oe;            // pin driven
        logic       analogEn;      // current-source DAC drives pin
        logic [5:0] dacValue;      // code for that DAC
    } aux_drive_s;

endpackage : aux_test_pkg

// ### hdl/aux_test_output_select.sv
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

module aux_test_output_select (
    input  wire logic                        clk,              // 100 MHz clock
    input  wire logic                        nrst,             // sync reset, active low
    input  wire logic [7:0]                  avsAddress,       // byte address
    input  wire logic                        avsRead,          // read request
    input  wire logic                        avsWrite,         // write request
    input  wire logic [31:0]                 avsWritedata,     // write data
    input  wire logic [3:0]                  avsByteenable,    // byte lanes
    output logic [31:0]                      avsReaddata,      // read data
    output logic                             avsWaitrequest,   // stall
    output logic [1:0]                       avsResponse,      // 00 ok, 10 slave error
    input  wire aux_test_pkg::frame_status_s frameStatus,      // transceiver status
    input  wire aux_test_pkg::analog_in_s    analogIn,         // analog samples
    input  wire logic [7:0]                  testBus,          // internal test bus
    output aux_test_pkg::aux_drive_s         firstTestPin,     // first pin drive
    output aux_test_pkg::aux_drive_s         secondTestPin     // second pin drive
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // software-visible storage
    logic [7:0] auxSel_q;
    logic [5:0] dacOne_q;
    logic [5:0] dacTwo_q;
    logic [1:0] dacOneRsvd_q;
    logic [7:0] prodTest_q [4];
    logic [2:0] testBusBitChoice_q;
    // bus answer state
    logic       ack_q;
    logic [31:0] readData_q;
    logic [1:0] resp_q;
    aux_test_pkg::aux_drive_s firstDrive_q;
    aux_test_pkg::aux_drive_s secondDrive_q;
    aux_test_pkg::aux_drive_s firstDrive_d;
    aux_test_pkg::aux_drive_s secondDrive_d;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic [5:0] regIdx;
    logic       req;
    logic       wrLow;
    logic       mapped;

    // ack masks the second cycle of a held request
    assign regIdx = avsAddress[7:2];
    assign req    = (avsRead | avsWrite) & ~ack_q;
    assign wrLow  = avsWrite & req & avsByteenable[0];

    // one strobe per writable register, except wrProd, which serves all four scratch bytes
    logic wrSel;
    logic wrDacOne;
    logic wrDacTwo;
    logic wrProd;
    logic wrTestSel;

    assign wrSel     = wrLow & (regIdx == aux_test_pkg::IDX_AUX_SEL);
    assign wrDacOne  = wrLow & (regIdx == aux_test_pkg::IDX_DAC_ONE);
    assign wrDacTwo  = wrLow & (regIdx == aux_test_pkg::IDX_DAC_TWO);
    assign wrProd    = wrLow & (regIdx >= aux_test_pkg::IDX_PROD_A);
    assign wrTestSel = wrLow & (regIdx == aux_test_pkg::IDX_TEST_SEL);

    // which indices answer without error
    function automatic logic isMapped(input logic [5:0] idx);
        isMapped = (idx == aux_test_pkg::IDX_TEST_SEL) ||
                   (idx >= aux_test_pkg::IDX_AUX_SEL);
    endfunction : isMapped

    // unmapped indices answer with slave error
    assign mapped = isMapped(regIdx);

    // one wait cycle: answer on the edge after the request is seen
    assign avsWaitrequest = (avsRead | avsWrite) & ~ack_q;
    assign avsReaddata    = readData_q;
    assign avsResponse    = resp_q;

    // ack pulses for one cycle so a held request is taken once
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // ------------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------------
    // pin selectors; reset leaves both pins high impedance
    always_ff @(posedge clk) begin
        if (!nrst) begin
            auxSel_q <= aux_test_pkg::RST_AUX_SEL;
        end else if (wrSel) begin
            auxSel_q <= avsWritedata[7:0];
        end
    end

    // test DAC one value; reserved bits 7:6 read as zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dacOne_q <= aux_test_pkg::RST_DAC[5:0];
        end else if (wrDacOne) begin
            dacOne_q <= avsWritedata[aux_test_pkg::DAC_VALUE_MSB:0];
        end
    end

    // test DAC two value; reserved bits 7:6 read as zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dacTwo_q <= aux_test_pkg::RST_DAC[5:0];
        end else if (wrDacTwo) begin
            dacTwo_q <= avsWritedata[aux_test_pkg::DAC_VALUE_MSB:0];
        end
    end

    // production-test scratch; no function, just keeps its value
    always_ff @(posedge clk) begin
        if (!nrst) begin
            prodTest_q[0] <= aux_test_pkg::RST_PROD_A;
            prodTest_q[1] <= aux_test_pkg::RST_PROD_B;
            prodTest_q[2] <= aux_test_pkg::RST_PROD_C;
            prodTest_q[3] <= aux_test_pkg::RST_PROD_D;
        end else if (wrProd) begin
            prodTest_q[regIdx[1:0]] <= avsWritedata[7:0];
        end
    end

    // test-bus bit choice
    always_ff @(posedge clk) begin
        if (!nrst) begin
            testBusBitChoice_q <= aux_test_pkg::RST_TEST_SEL;
        end else if (wrTestSel) begin
            testBusBitChoice_q <= avsWritedata[2:0];
        end
    end

    // reserved bits hold no storage
    assign dacOneRsvd_q = 2'h0;

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // response code, set as each request is taken
    always_ff @(posedge clk) begin
        if (!nrst) begin
            resp_q <= 2'h0;
        end else if (req) begin
            resp_q <= mapped ? 2'h0 : 2'h2;
        end
    end

    // adc register is live state; writes to it are dropped
    always_ff @(posedge clk) begin
        if (!nrst) begin
            readData_q <= 32'h0000_0000;
        end else if (req) begin
            readData_q <= 32'h0000_0000;
            if (avsRead) begin
                unique case (regIdx)
                    aux_test_pkg::IDX_AUX_SEL: readData_q[7:0] <= auxSel_q;
                    aux_test_pkg::IDX_DAC_ONE: readData_q[7:0] <= {dacOneRsvd_q, dacOne_q};
                    aux_test_pkg::IDX_DAC_TWO: readData_q[7:0] <= {2'h0, dacTwo_q};
                    aux_test_pkg::IDX_ADC_IQ:  readData_q[7:0] <=
                        {analogIn.adcI, analogIn.adcQ};
                    // scratch bytes read back as written
                    aux_test_pkg::IDX_PROD_A,
                    aux_test_pkg::IDX_PROD_B,
                    aux_test_pkg::IDX_PROD_C,
                    aux_test_pkg::IDX_PROD_D:  readData_q[7:0] <= prodTest_q[regIdx[1:0]];
                    aux_test_pkg::IDX_TEST_SEL: readData_q[7:0] <= {5'h00, testBusBitChoice_q};
                    // unmapped indices read zero
                    default:                   readData_q[7:0] <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // activity windows
    // ------------------------------------------------------------------
    // activity levels shared by both pins
    logic txWindow;
    logic rxWindow;
    logic subcarrierWin;

    // at 106 kBd the transmit window also covers the start bit
    always_comb begin
        txWindow = 1'b0;
        rxWindow = 1'b0;
        if (frameStatus.baseRate) begin
            txWindow = frameStatus.txPhase inside {aux_test_pkg::PH_START,
                       aux_test_pkg::PH_DATA, aux_test_pkg::PH_PARITY,
                       aux_test_pkg::PH_CRC};
            rxWindow = frameStatus.rxPhase inside {aux_test_pkg::PH_DATA,
                       aux_test_pkg::PH_PARITY, aux_test_pkg::PH_CRC};
        end else begin
            // higher rates: no start bit or parity
            txWindow = frameStatus.txPhase inside {aux_test_pkg::PH_DATA,
                       aux_test_pkg::PH_CRC};
            rxWindow = frameStatus.rxPhase inside {aux_test_pkg::PH_DATA,
                       aux_test_pkg::PH_CRC};
        end
    end

    // meaningless at the base rate, so held low there
    assign subcarrierWin = frameStatus.subcarrier & ~frameStatus.baseRate &
                           (frameStatus.rxPhase inside {aux_test_pkg::PH_DATA,
                            aux_test_pkg::PH_CRC});

    // ------------------------------------------------------------------
    // pin multiplexer
    // ------------------------------------------------------------------
    // one selector to one pin drive; the same code set serves both pins
    function automatic aux_test_pkg::aux_drive_s pinDrive(
        input logic [3:0] sel,
        input logic [5:0] dacValue,
        input logic       txWin,
        input logic       rxWin,
        input logic       scWin,
        input logic       busBit,
        input aux_test_pkg::analog_in_s ain
    );
        aux_test_pkg::aux_drive_s d;
        d = '0;
        unique case (sel)
            aux_test_pkg::SEL_TRISTATE: d.oe = 1'b0;
            // each pin takes its own DAC value
            aux_test_pkg::SEL_TEST_DAC: begin
                d.oe       = 1'b1;
                d.analogEn = 1'b1;
                d.dacValue = dacValue;
            end
            // correlator leaves as a plain level
            aux_test_pkg::SEL_CORR_ONE: begin
                d.oe      = 1'b1;
                d.digital = ain.corrOne;
            end
            aux_test_pkg::SEL_MIN_LEVEL: begin
                d.oe       = 1'b1;
                d.analogEn = 1'b1;
                d.dacValue = ain.minimum_signal_level;
            end
            // 4-bit sample fills the DAC top bits
            aux_test_pkg::SEL_ADC_I: begin
                d.oe       = 1'b1;
                d.analogEn = 1'b1;
                d.dacValue = {ain.adcI, 2'h0};
            end
            aux_test_pkg::SEL_ADC_Q: begin
                d.oe       = 1'b1;
                d.analogEn = 1'b1;
                d.dacValue = {ain.adcQ, 2'h0};
            end
            // fixed levels for probing the pad
            aux_test_pkg::SEL_HIGH: begin
                d.oe      = 1'b1;
                d.digital = 1'b1;
            end
            aux_test_pkg::SEL_LOW: begin
                d.oe      = 1'b1;
                d.digital = 1'b0;
            end
            // windows follow the frame phase
            aux_test_pkg::SEL_TX_WINDOW: begin
                d.oe      = 1'b1;
                d.digital = txWin;
            end
            aux_test_pkg::SEL_RX_WINDOW: begin
                d.oe      = 1'b1;
                d.digital = rxWin;
            end
            // held low at base rate by the window
            aux_test_pkg::SEL_SUBCARRIER: begin
                d.oe      = 1'b1;
                d.digital = scWin;
            end
            // bit picked by the choice register
            aux_test_pkg::SEL_TEST_BUS: begin
                d.oe      = 1'b1;
                d.digital = busBit;
            end
            // reserved codes leave the pin undriven
            default: d.oe = 1'b0;
        endcase
        return d;
    endfunction : pinDrive

    // three choice bits cover all bus lines
    logic busBit;
    assign busBit = testBus[testBusBitChoice_q];

    // each pin has its own nibble of the selector register
    always_comb begin
        firstDrive_d  = pinDrive(auxSel_q[aux_test_pkg::FIRST_SEL_LSB +: 4], dacOne_q,
                                 txWindow, rxWindow, subcarrierWin, busBit,
                                 analogIn);
        secondDrive_d = pinDrive(auxSel_q[aux_test_pkg::SECOND_SEL_LSB +: 4], dacTwo_q,
                                 txWindow, rxWindow, subcarrierWin, busBit,
                                 analogIn);
    end

    // registered pin drive: one cycle of latency buys glitch-free pins
    always_ff @(posedge clk) begin
        if (!nrst) begin
            firstDrive_q <= '0;
        end else begin
            firstDrive_q <= firstDrive_d;
        end
    end

    // second pin, same latency so both move together
    always_ff @(posedge clk) begin
        if (!nrst) begin
            secondDrive_q <= '0;
        end else begin
            secondDrive_q <= secondDrive_d;
        end
    end

    // pins come straight from flops
    assign firstTestPin  = firstDrive_q;
    assign secondTestPin = secondDrive_q;

endmodule : aux_test_output_select

`default_nettype wire

// ### testbench/aux_test_output_select_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module aux_test_output_select_assertions (
    input wire logic                        clk,            // clock
    input wire logic                        nrst,           // sync reset
    input wire logic [7:0]                  avsAddress,     // byte address
    input wire logic                        avsWrite,       // write
    input wire logic [31:0]                 avsWritedata,   // write data
    input wire logic [3:0]                  avsByteenable,  // lanes
    input wire logic                        avsWaitrequest, // stall
    input wire aux_test_pkg::frame_status_s frameStatus,    // frame status
    input wire aux_test_pkg::analog_in_s    analogIn,       // samples
    input wire logic [7:0]                  testBus,        // test bus
    input wire aux_test_pkg::aux_drive_s    firstTestPin,   // pin one
    input wire aux_test_pkg::aux_drive_s    secondTestPin   // pin two
);
    // ------------
    // shadow state
    // ------------
    logic [7:0] selQ;
    logic [2:0] bitQ;
    logic       take;
    logic       busBit;
    logic       txOn;
    logic       rxOn;

    // a write lands on the edge where waitrequest is still high
    assign take = avsWrite && avsWaitrequest && avsByteenable[0];
    assign busBit = testBus[bitQ];
    assign txOn = frameStatus.txPhase inside {3'h2, 3'h4}
        || (frameStatus.baseRate && frameStatus.txPhase inside {3'h1, 3'h3});
    assign rxOn = frameStatus.rxPhase inside {3'h2, 3'h4}
        || (frameStatus.baseRate && frameStatus.rxPhase == 3'h3);

    // selector copy, tracks the design register edge for edge
    always_ff @(posedge clk) begin
        if (!nrst) begin
            selQ <= 8'h00;
        end else if (take && avsAddress[7:2] == 6'h38) begin
            selQ <= avsWritedata[7:0];
        end
    end

    // bit choice copy
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bitQ <= 3'h0;
        end else if (take && avsAddress[7:2] == 6'h31) begin
            bitQ <= avsWritedata[2:0];
        end
    end

    // ----------
    // assertions
    // ----------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_TRISTATE: assert property ($past(selQ[3:0]) == 4'h0 |-> !secondTestPin.oe)
        else $error("pin two driven in tristate");
    AST_LEVEL: assert property ($past(selQ[7:4]) inside {4'ha, 4'hb} |-> firstTestPin.oe
        && !firstTestPin.analogEn && firstTestPin.digital == !$past(selQ[4]))
        else $error("pin one fixed level wrong");
    AST_DAC_PATH: assert property ($past(selQ[3:0]) == 4'h1
        |-> secondTestPin.oe && secondTestPin.analogEn)
        else $error("pin two not on its dac");
    AST_TX: assert property ($past(selQ[7:4]) == 4'hc |-> firstTestPin.oe
        && firstTestPin.digital == $past(txOn))
        else $error("transmit window wrong");
    AST_RX: assert property ($past(selQ[3:0]) == 4'hd |-> secondTestPin.oe
        && secondTestPin.digital == $past(rxOn))
        else $error("receive window wrong");
    AST_SUBCARRIER: assert property ($past(selQ[7:4]) == 4'he
        && !$past(frameStatus.baseRate) |-> firstTestPin.digital
        == ($past(frameStatus.subcarrier) && $past(rxOn)))
        else $error("subcarrier window wrong");
    AST_TEST_BUS: assert property ($past(selQ[3:0]) == 4'hf
        |-> secondTestPin.oe && secondTestPin.digital == $past(busBit))
        else $error("test bus bit wrong");
    AST_MIN_LEVEL: assert property ($past(selQ[7:4]) == 4'h4 |-> firstTestPin.analogEn
        && firstTestPin.dacValue == $past(analogIn.minimum_signal_level))
        else $error("minimum level not on dac");
    AST_ADC_I: assert property ($past(selQ[7:4]) == 4'h5 |-> firstTestPin.analogEn
        && firstTestPin.dacValue[5:2] == $past(analogIn.adcI))
        else $error("adc i not on dac");

    // ------
    // covers
    // ------
    COV_TX: cover property ($past(selQ[7:4]) == 4'hc && firstTestPin.digital);
    COV_BUS: cover property ($past(selQ[3:0]) == 4'hf && secondTestPin.digital);
    COV_DAC: cover property (secondTestPin.analogEn);
endmodule : aux_test_output_select_assertions

bind aux_test_output_select aux_test_output_select_assertions chk (
    .clk(clk), .nrst(nrst), .avsAddress(avsAddress), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsWaitrequest(avsWaitrequest), .frameStatus(frameStatus), .analogIn(analogIn),
    .testBus(testBus), .firstTestPin(firstTestPin), .secondTestPin(secondTestPin)
);

`default_nettype wire

// ### testbench/aux_test_output_select_tb.sv
`timescale 1ns/100ps
`default_nettype none

module aux_test_output_select_tb;
    // -------
    // signals
    // -------
    logic                        clk, nrst, avsRead, avsWrite, avsWaitrequest;
    logic [7:0]                  avsAddress, testBus, rdQ;
    logic [31:0]                 avsWritedata, avsReaddata;
    logic [3:0]                  avsByteenable;
    logic [1:0]                  avsResponse, rspQ;
    logic [2:0]                  bitSel;
    aux_test_pkg::frame_status_s frameStatus;
    aux_test_pkg::analog_in_s    analogIn;
    aux_test_pkg::aux_drive_s    firstTestPin, secondTestPin;
    int                          errors, samples_checked;

    aux_test_output_select dut (
        .clk(clk), .nrst(nrst), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
        .avsResponse(avsResponse), .frameStatus(frameStatus), .analogIn(analogIn),
        .testBus(testBus), .firstTestPin(firstTestPin), .secondTestPin(secondTestPin)
    );

    // free running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // -----
    // tasks
    // -----
    task automatic conclude;
        $display("errors %0d checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic fail(input string m);
        errors++;
        $display("FAIL %0t %s", $time, m);
    endtask : fail

    // one bus cycle, entered just after a rising edge; waits are bounded
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        logic done;
        done = 1'b0;
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWritedata <= {24'h000000, d};
        // waitrequest and read data are taken at the same rising edge
        repeat (50) begin
            @(posedge clk);
            if (avsWaitrequest === 1'b0) begin
                done = 1'b1;
                break;
            end
        end
        rdQ = avsReaddata[7:0];
        rspQ = avsResponse;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        @(posedge clk);
        if (!done) begin
            fail("bus timeout");
            conclude();
        end
    endtask : xfer

    task automatic checkByte(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) fail($sformatf("byte %h expected %h", g, e));
    endtask : checkByte

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
        xfer(1'b0, a, 8'h00);
        checkByte(rdQ, e);
        checkByte({6'h00, rspQ}, {6'h00, r});
    endtask : rd

    // only what reaches the wire matters: level, or dac code when analog
    task automatic checkPin(input aux_test_pkg::aux_drive_s g, input aux_test_pkg::aux_drive_s e);
        samples_checked++;
        if (g.oe !== e.oe || (e.oe && (g.analogEn !== e.analogEn
            || (e.analogEn ? g.dacValue !== e.dacValue : g.digital !== e.digital))))
            fail($sformatf("pin %h expected %h", g, e));
    endtask : checkPin

    function automatic aux_test_pkg::aux_drive_s expPin(input logic [3:0] c, input logic [5:0] v);
        logic tx, rx, sc;
        tx = frameStatus.txPhase inside {3'h2, 3'h4}
            || (frameStatus.baseRate && frameStatus.txPhase inside {3'h1, 3'h3});
        rx = frameStatus.rxPhase inside {3'h2, 3'h4}
            || (frameStatus.baseRate && frameStatus.rxPhase == 3'h3);
        sc = frameStatus.subcarrier && !frameStatus.baseRate
            && frameStatus.rxPhase inside {3'h2, 3'h4};
        case (c)
            4'h1: expPin = {3'b011, v};
            4'h2: expPin = {analogIn.corrOne, 8'h80};
            4'h4: expPin = {3'b011, analogIn.minimum_signal_level};
            4'h5: expPin = {3'b011, analogIn.adcI, 2'b00};
            4'h6: expPin = {3'b011, analogIn.adcQ, 2'b00};
            4'ha: expPin = 9'h180;
            4'hb: expPin = 9'h080;
            4'hc: expPin = {tx, 8'h80};
            4'hd: expPin = {rx, 8'h80};
            4'he: expPin = {sc, 8'h80};
            4'hf: expPin = {testBus[bitSel], 8'h80};
            default: expPin = 9'h000;
        endcase
    endfunction : expPin

    // pins follow their inputs one edge later
    task automatic pinPair(input logic [3:0] a, input logic [3:0] b);
        @(posedge clk);
        @(negedge clk);
        checkPin(firstTestPin, expPin(a, 6'h3f));
        checkPin(secondTestPin, expPin(b, 6'h2a));
        @(posedge clk);
    endtask : pinPair

    // ---------
    // scenarios
    // ---------
    task automatic resetValues;
        pinPair(4'h0, 4'h0);
        rd(8'he0, 8'h00, 2'b00);
        rd(8'hf0, 8'hff, 2'b00);
        rd(8'hf4, 8'h00, 2'b00);
        rd(8'hf8, 8'h03, 2'b00);
        rd(8'hfc, 8'h00, 2'b00);
        rd(8'h00, 8'h00, 2'b10);
    endtask : resetValues

    task automatic adcRegister;
        rd(8'hec, 8'h96, 2'b00);
        xfer(1'b1, 8'hec, 8'h00);
        analogIn.adcI <= 4'h3;
        rd(8'hec, 8'h36, 2'b00);
    endtask : adcRegister

    task automatic dacRegisters;
        xfer(1'b1, 8'he4, 8'hff);
        rd(8'he4, 8'h3f, 2'b00);
        xfer(1'b1, 8'he8, 8'hea);
        rd(8'he8, 8'h2a, 2'b00);
    endtask : dacRegisters

    // every code on pin one, its complement on pin two
    task automatic selectorSweep;
        for (int c = 0; c < 16; c++) begin
            xfer(1'b1, 8'he0, {4'(c), ~4'(c)});
            rd(8'he0, {4'(c), ~4'(c)}, 2'b00);
            pinPair(4'(c), ~4'(c));
        end
    endtask : selectorSweep

    // all phases at both rates, rx phase reversed to catch swaps
    task automatic frameWindows;
        for (int s = 0; s < 2; s++) begin
            xfer(1'b1, 8'he0, s ? 8'hef : 8'hcd);
            for (int r = 0; r < 2; r++) begin
                for (int p = 0; p < 5; p++) begin
                    bitSel = 3'(p);
                    xfer(1'b1, 8'hc4, 8'(p));
                    frameStatus <= {3'(p), 3'(4 - p), r[0], p != 2};
                    pinPair(s ? 4'he : 4'hc, s ? 4'hf : 4'hd);
                end
            end
        end
    endtask : frameWindows

    // ----
    // main
    // ----
    initial begin
        nrst = 1'b0;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsAddress = 8'h00;
        avsWritedata = 32'h00000000;
        avsByteenable = 4'h1;
        frameStatus = '0;
        analogIn = {4'h9, 4'h6, 6'h2d, 1'b1};
        testBus = 8'ha5;
        bitSel = 3'h0;
        errors = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        resetValues();
        adcRegister();
        dacRegisters();
        selectorSweep();
        frameWindows();
        conclude();
    end
endmodule : aux_test_output_select_tb

`default_nettype wire
